/* hw/bsbu_top.sv */
// bsbu_top: executes skip, branch and bit instructions on loaded operands.
// assumes an APB master on REF_CLK; software loads operands, then writes the command.
//
// Function
// [RULE1] skip on general register bit zero: pc plus 2 or 3, 1/2/3 cycles
// [RULE2] skip on general register bit one, same pc advance and cycle counts
// [RULE3] skip on i/o register bit zero or one, 1 to 3 cycles, no flags
// [RULE4] branch when flag s is one: pc plus k plus 1, 1/2 cycles
// [RULE5] branch when flag s is zero: pc plus k plus 1, else fall through
// [RULE6] carry-clear and unsigned same-or-higher branch taken when carry is zero
// [RULE7] carry-set and unsigned lower branch taken when carry is one
// [RULE8] minus branch on negative one, plus branch on negative zero
// [RULE9] signed compare branches test negative xor overflow: ge on zero, lt on one
// [RULE10] half-carry branches taken on half-carry one or zero
// [RULE11] transfer-flag branches taken on transfer one or zero, no flag change
// [RULE12] overflow branches taken on overflow one or zero
// [RULE13] interrupt-state branches test the global interrupt enable flag
// [RULE14] i/o bit set writes one to bit b only, two cycles, no flags
// [RULE15] i/o bit clear writes zero to bit b only, two cycles, no flags
// [RULE16] logical shifts fill zero and update zero, carry, negative, overflow
// [RULE17] rotate left takes carry into bit 0, old bit 7 into carry
// [RULE18] rotate right takes carry into bit 7, old bit 0 into carry
// [RULE19] bit store copies register bit b into transfer flag only
// [RULE20] bit load copies transfer flag into register bit b, no flags
// [RULE21] carry, negative and zero flags each set or cleared alone
// [RULE22] interrupt enable sets i flag; generic set and clear write any flag
// [RULE23] interrupt disable clears only the i flag in one cycle
// [RULE24] equal and not-equal branch on zero flag; nibble swap leaves flags alone
// [RULE25] arithmetic right shift keeps bit 7, bit 0 into carry, updates flags
`timescale 1ns/10ps

module bsbu_top
	import bsbu_pkg::*;
(
	// clock, reset, enable
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic CE,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [bsbu_pkg::ADDR_W-1:0] PADDR,
	input wire logic [bsbu_pkg::DATA_W-1:0] PWDATA,
	output logic [bsbu_pkg::DATA_W-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// execution status
	output logic BUSY
);
	import bsbu_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// helper functions
	// zero test of a byte
	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == RST_BYTE);
	endfunction
	// program counter step, wraps at the top
	function automatic logic [PC_W-1:0] pc_add(input logic [PC_W-1:0] p,
		input logic [PC_W-1:0] d);
		pc_add = p + d;
	endfunction
	// replace one bit of a byte
	function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] b,
		input logic x);
		logic [7:0] r;
		r = v;
		r[b] = x;
		put_bit = r;
	endfunction
	// shift flags: zero, carry, negative, overflow = negative xor carry
	function automatic logic [7:0] shift_flags(input logic [7:0] f, input logic [7:0] res,
		input logic c);
		logic [7:0] r;
		r = f;
		r[FL_Z] = is_zero(res);
		r[FL_C] = c;
		r[FL_N] = res[7];
		r[FL_V] = res[7] ^ c;
		shift_flags = r;
	endfunction
	////////////////////////////////////////////////////////////////////////
	// state
	bsbu_state_type state_ff;
	bsbu_state_type nxt_state;
	logic [OP_W-1:0] op_ff;
	logic [2:0] bit_ff;
	logic [2:0] flag_sel_ff;
	logic [PC_W-1:0] pc_ff;
	logic [7:0] flags_ff;
	logic [7:0] gpr_ff;
	logic [7:0] io_ff;
	logic [K_W-1:0] k_ff;
	logic long_next_ff;
	logic taken_ff;
	logic [CNT_W-1:0] cycles_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [DATA_W-1:0] prdata_ff;
	// execution results
	logic [PC_W-1:0] nxt_pc;
	logic [7:0] nxt_flags;
	logic [7:0] nxt_gpr;
	logic [7:0] nxt_io;
	logic nxt_taken;
	logic [CNT_W-1:0] nxt_cycles;
	// bus decode
	logic acc;
	logic wr_acc;
	logic rd_setup;
	logic addr_ok;
	logic wr_err;
	logic cmd_op_ok;
	logic commit;
	logic [DATA_W-1:0] rd_data;
	logic [PC_W-1:0] k_ext;
	logic branch_cond;
	logic skip_cond;

	////////////////////////////////////////////////////////////////////////
	// apb decode
	// zero wait states while enabled; frozen clock enable stalls the bus
	assign PREADY = CE;
	assign acc = PSEL & PENABLE & CE;
	assign wr_acc = acc & PWRITE & ~wr_err;
	assign rd_setup = PSEL & ~PENABLE & ~PWRITE & CE;
	assign cmd_op_ok = (PWDATA[CMD_OP_LSB +: OP_W] <= OP_LAST);
	// address map check
	always_comb begin
		case (PADDR)
			OFF_CMD, OFF_PC, OFF_FLAGS, OFF_GPR, OFF_IO, OFF_OPND, OFF_STAT: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	// writes refused: unmapped, read-only status, while busy, unknown op
	always_comb begin
		wr_err = 1'b0;
		if (PWRITE) begin
			if (!addr_ok || PADDR == OFF_STAT || state_ff == BSBU_EXEC) begin
				wr_err = 1'b1;
			end else if (PADDR == OFF_CMD && !cmd_op_ok) begin
				wr_err = 1'b1;
			end
		end
	end
	assign PSLVERR = acc & (PWRITE ? wr_err : ~addr_ok);
	// read mux
	always_comb begin
		rd_data = '0;
		case (PADDR)
			OFF_CMD: begin
				rd_data[CMD_OP_LSB +: OP_W] = op_ff;
				rd_data[CMD_B_LSB +: 3] = bit_ff;
				rd_data[CMD_S_LSB +: 3] = flag_sel_ff;
			end
			OFF_PC: rd_data[PC_W-1:0] = pc_ff;
			OFF_FLAGS: rd_data[7:0] = flags_ff;
			OFF_GPR: rd_data[7:0] = gpr_ff;
			OFF_IO: rd_data[7:0] = io_ff;
			OFF_OPND: begin
				rd_data[OPND_K_LSB +: K_W] = k_ff;
				rd_data[OPND_LONG_BIT] = long_next_ff;
			end
			OFF_STAT: begin
				rd_data[STAT_BUSY_BIT] = (state_ff == BSBU_EXEC);
				rd_data[STAT_TAKEN_BIT] = taken_ff;
				rd_data[STAT_CYC_LSB +: CNT_W] = cycles_ff;
			end
			default: rd_data = '0;
		endcase
	end
	// read data captured in the setup phase
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			prdata_ff <= '0;
		end else if (rd_setup) begin
			prdata_ff <= rd_data;
		end
	end
	assign PRDATA = prdata_ff;
	////////////////////////////////////////////////////////////////////////
	// execution of the loaded instruction
	assign k_ext = {{(PC_W-K_W){k_ff[K_W-1]}}, k_ff};

	// named and generic branch conditions
	always_comb begin
		case (op_ff)
			OP_BRANCH_ON_FLAG_ONE: branch_cond = flags_ff[flag_sel_ff]; // [RULE4]
			OP_BRANCH_ON_FLAG_ZERO: branch_cond = ~flags_ff[flag_sel_ff]; // [RULE5]
			OP_BRANCH_EQUAL: branch_cond = flags_ff[FL_Z]; // [RULE24]
			OP_BRANCH_NOT_EQUAL: branch_cond = ~flags_ff[FL_Z]; // [RULE24]
			OP_BRANCH_ON_CARRY_ONE, OP_BRANCH_UNSIGNED_LT: branch_cond = flags_ff[FL_C]; // [RULE7]
			OP_BRANCH_ON_CARRY_ZERO, OP_BRANCH_UNSIGNED_GE: branch_cond = ~flags_ff[FL_C]; // [RULE6]
			OP_BRANCH_NEGATIVE: branch_cond = flags_ff[FL_N]; // [RULE8]
			OP_BRANCH_POSITIVE: branch_cond = ~flags_ff[FL_N]; // [RULE8]
			OP_BRANCH_SIGNED_GE: branch_cond = ~(flags_ff[FL_N] ^ flags_ff[FL_V]); // [RULE9]
			OP_BRANCH_SIGNED_LT: branch_cond = flags_ff[FL_N] ^ flags_ff[FL_V]; // [RULE9]
			OP_BRANCH_HALFCARRY_ONE: branch_cond = flags_ff[FL_H]; // [RULE10]
			OP_BRANCH_HALFCARRY_ZERO: branch_cond = ~flags_ff[FL_H]; // [RULE10]
			OP_BRANCH_TRANSFER_ONE: branch_cond = flags_ff[FL_T]; // [RULE11]
			OP_BRANCH_TRANSFER_ZERO: branch_cond = ~flags_ff[FL_T]; // [RULE11]
			OP_BRANCH_OVERFLOW_ONE: branch_cond = flags_ff[FL_V]; // [RULE12]
			OP_BRANCH_OVERFLOW_ZERO: branch_cond = ~flags_ff[FL_V]; // [RULE12]
			OP_BRANCH_IRQ_ENABLED: branch_cond = flags_ff[FL_I]; // [RULE13]
			OP_BRANCH_IRQ_DISABLED: branch_cond = ~flags_ff[FL_I]; // [RULE13]
			default: branch_cond = 1'b0;
		endcase
	end

	// skip conditions on register or i/o bit
	always_comb begin
		case (op_ff)
			OP_SKIP_IF_REG_BIT_ZERO: skip_cond = ~gpr_ff[bit_ff]; // [RULE1]
			OP_SKIP_IF_REG_BIT_ONE: skip_cond = gpr_ff[bit_ff]; // [RULE2]
			OP_SKIP_IF_IO_BIT_ZERO: skip_cond = ~io_ff[bit_ff]; // [RULE3]
			OP_SKIP_IF_IO_BIT_ONE: skip_cond = io_ff[bit_ff]; // [RULE3]
			default: skip_cond = 1'b0;
		endcase
	end

	// results, program counter and cycle count of the instruction
	always_comb begin
		nxt_pc = pc_add(pc_ff, PC_STEP);
		nxt_flags = flags_ff;
		nxt_gpr = gpr_ff;
		nxt_io = io_ff;
		nxt_taken = 1'b0;
		nxt_cycles = CYC_ONE;
		case (op_ff)
			OP_SKIP_IF_REG_BIT_ZERO, OP_SKIP_IF_REG_BIT_ONE,
			OP_SKIP_IF_IO_BIT_ZERO, OP_SKIP_IF_IO_BIT_ONE: begin
				// skipped word count sets both pc step and cycles
				if (skip_cond) begin
					nxt_taken = 1'b1;
					nxt_pc = pc_add(pc_ff, long_next_ff ? PC_SKIP_LONG : PC_SKIP_SHORT); // [RULE1]
					nxt_cycles = long_next_ff ? CYC_THREE : CYC_TWO; // [RULE2] [RULE3]
				end
			end
			OP_BRANCH_ON_FLAG_ONE, OP_BRANCH_ON_FLAG_ZERO, OP_BRANCH_EQUAL,
			OP_BRANCH_NOT_EQUAL, OP_BRANCH_ON_CARRY_ONE, OP_BRANCH_ON_CARRY_ZERO,
			OP_BRANCH_UNSIGNED_GE, OP_BRANCH_UNSIGNED_LT, OP_BRANCH_NEGATIVE,
			OP_BRANCH_POSITIVE, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
			OP_BRANCH_HALFCARRY_ONE, OP_BRANCH_HALFCARRY_ZERO, OP_BRANCH_TRANSFER_ONE,
			OP_BRANCH_TRANSFER_ZERO, OP_BRANCH_OVERFLOW_ONE, OP_BRANCH_OVERFLOW_ZERO,
			OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED: begin
				// taken: pc plus k plus 1 in two cycles, flags untouched
				if (branch_cond) begin
					nxt_taken = 1'b1;
					nxt_pc = pc_add(pc_add(pc_ff, k_ext), PC_STEP); // [RULE4] [RULE5]
					nxt_cycles = CYC_TWO; // [RULE11]
				end
			end
			OP_IO_BIT_WRITE_ONE: begin
				nxt_io = put_bit(io_ff, bit_ff, 1'b1); // [RULE14]
				nxt_cycles = CYC_TWO; // [RULE14]
			end
			OP_IO_BIT_WRITE_ZERO: begin
				nxt_io = put_bit(io_ff, bit_ff, 1'b0); // [RULE15]
				nxt_cycles = CYC_TWO; // [RULE15]
			end
			OP_LOGIC_SHIFT_LEFT: begin
				nxt_gpr = {gpr_ff[6:0], 1'b0}; // [RULE16]
				nxt_flags = shift_flags(flags_ff, {gpr_ff[6:0], 1'b0}, gpr_ff[7]); // [RULE16]
			end
			OP_LOGIC_SHIFT_RIGHT: begin
				nxt_gpr = {1'b0, gpr_ff[7:1]}; // [RULE16]
				nxt_flags = shift_flags(flags_ff, {1'b0, gpr_ff[7:1]}, gpr_ff[0]); // [RULE16]
			end
			OP_ROTATE_UP_THROUGH_CARRY: begin
				nxt_gpr = {gpr_ff[6:0], flags_ff[FL_C]}; // [RULE17]
				nxt_flags = shift_flags(flags_ff, {gpr_ff[6:0], flags_ff[FL_C]}, gpr_ff[7]); // [RULE17]
			end
			OP_ROTATE_DOWN_THROUGH_CARRY: begin
				nxt_gpr = {flags_ff[FL_C], gpr_ff[7:1]}; // [RULE18]
				nxt_flags = shift_flags(flags_ff, {flags_ff[FL_C], gpr_ff[7:1]}, gpr_ff[0]); // [RULE18]
			end
			OP_ARITH_SHIFT_RIGHT: begin
				nxt_gpr = {gpr_ff[7], gpr_ff[7:1]}; // [RULE25]
				nxt_flags = shift_flags(flags_ff, {gpr_ff[7], gpr_ff[7:1]}, gpr_ff[0]); // [RULE25]
			end
			OP_NIBBLE_SWAP: nxt_gpr = {gpr_ff[3:0], gpr_ff[7:4]}; // [RULE24]
			OP_FLAG_FORCE_ONE: nxt_flags = put_bit(flags_ff, flag_sel_ff, 1'b1); // [RULE22]
			OP_FLAG_FORCE_ZERO: nxt_flags = put_bit(flags_ff, flag_sel_ff, 1'b0); // [RULE22]
			OP_REG_BIT_TO_TRANSFER: nxt_flags[FL_T] = gpr_ff[bit_ff]; // [RULE19]
			OP_TRANSFER_TO_REG_BIT: nxt_gpr = put_bit(gpr_ff, bit_ff, flags_ff[FL_T]); // [RULE20]
			OP_CARRY_FORCE_ONE: nxt_flags[FL_C] = 1'b1; // [RULE21]
			OP_CARRY_FORCE_ZERO: nxt_flags[FL_C] = 1'b0; // [RULE21]
			OP_NEGATIVE_FORCE_ONE: nxt_flags[FL_N] = 1'b1; // [RULE21]
			OP_NEGATIVE_FORCE_ZERO: nxt_flags[FL_N] = 1'b0; // [RULE21]
			OP_ZERO_FLAG_FORCE_ONE: nxt_flags[FL_Z] = 1'b1; // [RULE21]
			OP_ZERO_FLAG_FORCE_ZERO: nxt_flags[FL_Z] = 1'b0; // [RULE21]
			OP_GLOBAL_IRQ_ON: nxt_flags[FL_I] = 1'b1; // [RULE22]
			OP_GLOBAL_IRQ_OFF: nxt_flags[FL_I] = 1'b0; // [RULE23]
			default: nxt_cycles = CYC_ONE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// sequencing
	// last execution cycle writes the results back
	assign commit = (state_ff == BSBU_EXEC) && (cnt_ff == nxt_cycles);
	assign BUSY = (state_ff == BSBU_EXEC);
	// idle until a command is written, exec for the instruction's cycles
	always_comb begin
		case (state_ff)
			BSBU_IDLE: nxt_state = (wr_acc && PADDR == OFF_CMD) ? BSBU_EXEC : BSBU_IDLE;
			BSBU_EXEC: nxt_state = commit ? BSBU_IDLE : BSBU_EXEC;
			default: nxt_state = BSBU_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			state_ff <= BSBU_IDLE;
		end else if (CE) begin
			state_ff <= nxt_state;
		end
	end

	// execution cycle counter, first exec cycle counts one
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			cnt_ff <= CYC_ONE;
		end else if (CE) begin
			if (state_ff == BSBU_EXEC && !commit) begin
				cnt_ff <= cnt_ff + CYC_ONE;
			end else begin
				cnt_ff <= CYC_ONE;
			end
		end
	end

	// command fields
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			op_ff <= '0;
			bit_ff <= '0;
			flag_sel_ff <= '0;
		end else if (CE && wr_acc && PADDR == OFF_CMD) begin
			op_ff <= PWDATA[CMD_OP_LSB +: OP_W];
			bit_ff <= PWDATA[CMD_B_LSB +: 3];
			flag_sel_ff <= PWDATA[CMD_S_LSB +: 3];
		end
	end

	// branch offset and length of the following instruction
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			k_ff <= '0;
			long_next_ff <= 1'b0;
		end else if (CE && wr_acc && PADDR == OFF_OPND) begin
			k_ff <= PWDATA[OPND_K_LSB +: K_W];
			long_next_ff <= PWDATA[OPND_LONG_BIT];
		end
	end

	// program counter, software load or result
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			pc_ff <= RST_PC;
		end else if (CE) begin
			if (commit) begin
				pc_ff <= nxt_pc;
			end else if (wr_acc && PADDR == OFF_PC) begin
				pc_ff <= PWDATA[PC_W-1:0];
			end
		end
	end

	// status flags, general register and i/o register
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			flags_ff <= RST_BYTE;
			gpr_ff <= RST_BYTE;
			io_ff <= RST_BYTE;
		end else if (CE) begin
			if (commit) begin
				flags_ff <= nxt_flags;
				gpr_ff <= nxt_gpr;
				io_ff <= nxt_io;
			end else if (wr_acc) begin
				if (PADDR == OFF_FLAGS) flags_ff <= PWDATA[7:0];
				if (PADDR == OFF_GPR) gpr_ff <= PWDATA[7:0];
				if (PADDR == OFF_IO) io_ff <= PWDATA[7:0];
			end
		end
	end

	// outcome of the last instruction
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			taken_ff <= 1'b0;
			cycles_ff <= '0;
		end else if (CE && commit) begin
			taken_ff <= nxt_taken;
			cycles_ff <= nxt_cycles;
		end
	end

endmodule

/* hw/bsbu_pkg.sv */
// bsbu_pkg: constants shared by the branch, skip and bit-operation unit.
// assumes a 32-bit APB slave with byte addresses, one aligned word per register.
package bsbu_pkg;

	// widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int PC_W = 16;
	localparam int K_W = 7;
	localparam int OP_W = 6;
	localparam int CNT_W = 2;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CMD = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_PC = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_GPR = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_IO = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_OPND = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h18;

	// command word fields: op [5:0], bit b [8:6], flag s [11:9]
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_B_LSB = 6;
	localparam int CMD_S_LSB = 9;
	// operand word fields: k [6:0], next instruction two words [8]
	localparam int OPND_K_LSB = 0;
	localparam int OPND_LONG_BIT = 8;
	// status word fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_TAKEN_BIT = 1;
	localparam int STAT_CYC_LSB = 2;

	// status flag bit positions
	localparam int FL_C = 0;
	localparam int FL_Z = 1;
	localparam int FL_N = 2;
	localparam int FL_V = 3;
	localparam int FL_S = 4;
	localparam int FL_H = 5;
	localparam int FL_T = 6;
	localparam int FL_I = 7;

	// reset values
	localparam logic [PC_W-1:0] RST_PC = 16'h0000;
	localparam logic [7:0] RST_BYTE = 8'h00;

	// cycle counts and program counter steps
	localparam logic [CNT_W-1:0] CYC_ONE = 2'h1;
	localparam logic [CNT_W-1:0] CYC_TWO = 2'h2;
	localparam logic [CNT_W-1:0] CYC_THREE = 2'h3;
	localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
	localparam logic [PC_W-1:0] PC_SKIP_SHORT = 16'h0002;
	localparam logic [PC_W-1:0] PC_SKIP_LONG = 16'h0003;

	// operation codes
	localparam logic [OP_W-1:0] OP_SKIP_IF_REG_BIT_ZERO = 6'h00;
	localparam logic [OP_W-1:0] OP_SKIP_IF_REG_BIT_ONE = 6'h01;
	localparam logic [OP_W-1:0] OP_SKIP_IF_IO_BIT_ZERO = 6'h02;
	localparam logic [OP_W-1:0] OP_SKIP_IF_IO_BIT_ONE = 6'h03;
	localparam logic [OP_W-1:0] OP_BRANCH_ON_FLAG_ONE = 6'h04;
	localparam logic [OP_W-1:0] OP_BRANCH_ON_FLAG_ZERO = 6'h05;
	localparam logic [OP_W-1:0] OP_BRANCH_EQUAL = 6'h06;
	localparam logic [OP_W-1:0] OP_BRANCH_NOT_EQUAL = 6'h07;
	localparam logic [OP_W-1:0] OP_BRANCH_ON_CARRY_ONE = 6'h08;
	localparam logic [OP_W-1:0] OP_BRANCH_ON_CARRY_ZERO = 6'h09;
	localparam logic [OP_W-1:0] OP_BRANCH_UNSIGNED_GE = 6'h0a;
	localparam logic [OP_W-1:0] OP_BRANCH_UNSIGNED_LT = 6'h0b;
	localparam logic [OP_W-1:0] OP_BRANCH_NEGATIVE = 6'h0c;
	localparam logic [OP_W-1:0] OP_BRANCH_POSITIVE = 6'h0d;
	localparam logic [OP_W-1:0] OP_BRANCH_SIGNED_GE = 6'h0e;
	localparam logic [OP_W-1:0] OP_BRANCH_SIGNED_LT = 6'h0f;
	localparam logic [OP_W-1:0] OP_BRANCH_HALFCARRY_ONE = 6'h10;
	localparam logic [OP_W-1:0] OP_BRANCH_HALFCARRY_ZERO = 6'h11;
	localparam logic [OP_W-1:0] OP_BRANCH_TRANSFER_ONE = 6'h12;
	localparam logic [OP_W-1:0] OP_BRANCH_TRANSFER_ZERO = 6'h13;
	localparam logic [OP_W-1:0] OP_BRANCH_OVERFLOW_ONE = 6'h14;
	localparam logic [OP_W-1:0] OP_BRANCH_OVERFLOW_ZERO = 6'h15;
	localparam logic [OP_W-1:0] OP_BRANCH_IRQ_ENABLED = 6'h16;
	localparam logic [OP_W-1:0] OP_BRANCH_IRQ_DISABLED = 6'h17;
	localparam logic [OP_W-1:0] OP_IO_BIT_WRITE_ONE = 6'h18;
	localparam logic [OP_W-1:0] OP_IO_BIT_WRITE_ZERO = 6'h19;
	localparam logic [OP_W-1:0] OP_LOGIC_SHIFT_LEFT = 6'h1a;
	localparam logic [OP_W-1:0] OP_LOGIC_SHIFT_RIGHT = 6'h1b;
	localparam logic [OP_W-1:0] OP_ROTATE_UP_THROUGH_CARRY = 6'h1c;
	localparam logic [OP_W-1:0] OP_ROTATE_DOWN_THROUGH_CARRY = 6'h1d;
	localparam logic [OP_W-1:0] OP_ARITH_SHIFT_RIGHT = 6'h1e;
	localparam logic [OP_W-1:0] OP_NIBBLE_SWAP = 6'h1f;
	localparam logic [OP_W-1:0] OP_FLAG_FORCE_ONE = 6'h20;
	localparam logic [OP_W-1:0] OP_FLAG_FORCE_ZERO = 6'h21;
	localparam logic [OP_W-1:0] OP_REG_BIT_TO_TRANSFER = 6'h22;
	localparam logic [OP_W-1:0] OP_TRANSFER_TO_REG_BIT = 6'h23;
	localparam logic [OP_W-1:0] OP_CARRY_FORCE_ONE = 6'h24;
	localparam logic [OP_W-1:0] OP_CARRY_FORCE_ZERO = 6'h25;
	localparam logic [OP_W-1:0] OP_NEGATIVE_FORCE_ONE = 6'h26;
	localparam logic [OP_W-1:0] OP_NEGATIVE_FORCE_ZERO = 6'h27;
	localparam logic [OP_W-1:0] OP_ZERO_FLAG_FORCE_ONE = 6'h28;
	localparam logic [OP_W-1:0] OP_ZERO_FLAG_FORCE_ZERO = 6'h29;
	localparam logic [OP_W-1:0] OP_GLOBAL_IRQ_ON = 6'h2a;
	localparam logic [OP_W-1:0] OP_GLOBAL_IRQ_OFF = 6'h2b;
	localparam logic [OP_W-1:0] OP_LAST = 6'h2b;

	// execution states, one-hot
	typedef enum logic [1:0] {
		BSBU_IDLE = 2'b01,
		BSBU_EXEC = 2'b10
	} bsbu_state_type;

endpackage

/* dv/bsbu_top_assertions.sv */
// bsbu_top_assertions: port checks on bus answers and execution length.
// assumes binding onto bsbu_top, one clock REF_CLK, reset NRST.
`timescale 1ns/10ps

module bsbu_chk
	import bsbu_pkg::*;
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic CE,
	// apb
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [bsbu_pkg::ADDR_W-1:0] PADDR,
	input wire logic [bsbu_pkg::DATA_W-1:0] PWDATA,
	input wire logic [bsbu_pkg::DATA_W-1:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// status
	input wire logic BUSY
);
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (!NRST);

	// accepted access, accepted command and its op code
	wire logic acc = PSEL && PENABLE && CE;
	wire logic [5:0] op = PWDATA[5:0];
	wire logic cmd = acc && PWRITE && !BUSY && PADDR == OFF_CMD && op <= OP_LAST;

	// execution length per instruction group
	skip_length_a:
	assert property (cmd && op <= OP_SKIP_IF_IO_BIT_ONE |=> BUSY ##[1:3] !BUSY)
		else $error("skip busy length wrong");
	branch_length_a:
	assert property (cmd && op >= OP_BRANCH_ON_FLAG_ONE && op <= OP_BRANCH_IRQ_DISABLED
		|=> BUSY ##[1:2] !BUSY) else $error("branch busy length wrong");
	io_bit_length_a:
	assert property (cmd && (op == OP_IO_BIT_WRITE_ONE || op == OP_IO_BIT_WRITE_ZERO)
		|=> BUSY [*2] ##1 !BUSY) else $error("io bit busy length wrong");
	single_cycle_a:
	assert property (cmd && op >= OP_LOGIC_SHIFT_LEFT |=> BUSY ##1 !BUSY)
		else $error("single cycle op busy length wrong");
	// bus answers
	busy_refuse_a:
	assert property (acc && PWRITE && BUSY |-> PSLVERR) else $error("write while busy taken");
	unmapped_a:
	assert property (acc && (PADDR > OFF_STAT || PADDR[1:0] != 2'h0) |-> PSLVERR)
		else $error("unmapped access not refused");
	bad_op_a:
	assert property (acc && PWRITE && PADDR == OFF_CMD && op > OP_LAST |-> PSLVERR)
		else $error("unknown op not refused");
	read_ok_a:
	assert property (acc && !PWRITE && PADDR <= OFF_STAT && PADDR[1:0] == 2'h0 |-> !PSLVERR)
		else $error("mapped read refused");
	busy_cause_a:
	assert property ($rose(BUSY) |-> $past(cmd)) else $error("busy without command");
	error_slot_a:
	assert property (!(PSEL && PENABLE) |-> !PSLVERR) else $error("error outside access");
endmodule

bind bsbu_top bsbu_chk chk_i (.REF_CLK, .NRST, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR,
	.PWDATA, .PRDATA, .PREADY, .PSLVERR, .BUSY);

/* dv/bsbu_tb.sv */
// bsbu_tb: register-level tests of skips, branches and bit operations.
// assumes bsbu_top with zero-wait apb; CE held high except for one low cycle in the bus stall check.
`timescale 1ns/10ps

module tb;
	import bsbu_pkg::*;
	logic REF_CLK, NRST, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, BUSY, e, t;
	logic [ADDR_W-1:0] PADDR;
	logic [DATA_W-1:0] PWDATA, PRDATA, q;
	logic [7:0] m, f0;
	logic [7:0] fl [5] = '{8'h00, 8'hff, 8'h0c, 8'h04, 8'h08};
	int fb [4] = '{FL_C, FL_N, FL_Z, FL_I};
	int bad_count, compares;

	bsbu_top uut (.REF_CLK(REF_CLK), .NRST(NRST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .BUSY(BUSY));

	// free-running clock
	initial begin
		REF_CLK = 1'b0;
		forever #2 REF_CLK = ~REF_CLK;
	end

	////////////////////////////////////////////////////////////
	// verdict and comparison
	task automatic give_verdict();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
		compares++;
		if (y !== x) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, x, y);
		end
	endtask

	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge REF_CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge REF_CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		if (PREADY !== 1'b1) begin
			bad_count++;
			give_verdict();
		end
		q = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(nm, x, q);
	endtask
	task automatic err(input logic w, input logic [7:0] a, input logic [31:0] d);
		apb(w, a, d);
		chk("refused", 32'h1, {31'h0, e});
	endtask

	// load operands {flags, gpr, io}, run one op from pc 0x20, check results
	task automatic run(input logic [5:0] op, input logic [2:0] b, input logic [8:0] k,
		input logic [23:0] v, input logic [7:0] xp, input logic [23:0] xv, input logic [2:0] xs);
		int n;
		apb(1'b1, OFF_PC, 32'h20);
		apb(1'b1, OFF_FLAGS, {24'h0, v[23:16]});
		apb(1'b1, OFF_GPR, {24'h0, v[15:8]});
		apb(1'b1, OFF_IO, {24'h0, v[7:0]});
		apb(1'b1, OFF_OPND, {23'h0, k});
		apb(1'b1, OFF_CMD, {20'h0, b, b, op});
		n = 0;
		do begin
			apb(1'b0, OFF_STAT, 32'h0);
			n++;
		end while (q[0] !== 1'b0 && n < 10);
		if (q[0] !== 1'b0) begin
			bad_count++;
			give_verdict();
		end
		rc("pc", OFF_PC, {24'h0, xp});
		rc("flags", OFF_FLAGS, {24'h0, xv[23:16]});
		rc("gpr", OFF_GPR, {24'h0, xv[15:8]});
		rc("io", OFF_IO, {24'h0, xv[7:0]});
		rc("stat", OFF_STAT, {28'h0, xs, 1'b0});
	endtask

	// expected outcome of a named branch
	function automatic logic tk(input logic [5:0] op, input logic [7:0] f);
		logic c;
		case (op[5:1])
			5'h03: c = f[FL_Z];
			5'h04, 5'h05: c = f[FL_C];
			5'h06: c = f[FL_N];
			5'h07: c = f[FL_N] ^ f[FL_V];
			5'h08: c = f[FL_H];
			5'h09: c = f[FL_T];
			5'h0a: c = f[FL_V];
			default: c = f[FL_I];
		endcase
		return (op[5:1] == 5'h05 || op[5:1] == 5'h07) ? c == op[0] : c != op[0];
	endfunction

	////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		NRST = 1'b0;
		CE = 1'b1;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h00;
		PWDATA = 32'h0;
		repeat (5) @(posedge REF_CLK);
		NRST <= 1'b1;
		for (int a = 0; a <= 24; a += 4) rc("reset", 8'(a), 32'h0);
		// a low clock enable must stall the bus
		CE <= 1'b0;
		@(posedge REF_CLK);
		chk("stalled ready", 32'h0, {31'h0, PREADY});
		CE <= 1'b1;
		run(OP_SKIP_IF_REG_BIT_ZERO, 3'h3, 9'h000, 24'h00f700, 8'h22, 24'h00f700, 3'h5);
		run(OP_SKIP_IF_REG_BIT_ZERO, 3'h3, 9'h100, 24'h000800, 8'h21, 24'h000800, 3'h2);
		run(OP_SKIP_IF_REG_BIT_ZERO, 3'h3, 9'h100, 24'h000000, 8'h23, 24'h000000, 3'h7);
		run(OP_SKIP_IF_REG_BIT_ONE, 3'h7, 9'h100, 24'h008000, 8'h23, 24'h008000, 3'h7);
		run(OP_SKIP_IF_REG_BIT_ONE, 3'h7, 9'h000, 24'h007f00, 8'h21, 24'h007f00, 3'h2);
		run(OP_SKIP_IF_IO_BIT_ZERO, 3'h0, 9'h000, 24'ha500fe, 8'h22, 24'ha500fe, 3'h5);
		run(OP_SKIP_IF_IO_BIT_ONE, 3'h5, 9'h000, 24'h000000, 8'h21, 24'h000000, 3'h2);
		run(OP_SKIP_IF_IO_BIT_ONE, 3'h5, 9'h100, 24'h5a0020, 8'h23, 24'h5a0020, 3'h7);
		run(OP_IO_BIT_WRITE_ONE, 3'h2, 9'h000, 24'h5a00a0, 8'h21, 24'h5a00a4, 3'h4);
		run(OP_IO_BIT_WRITE_ZERO, 3'h7, 9'h000, 24'h5a00ff, 8'h21, 24'h5a007f, 3'h4);
		run(OP_LOGIC_SHIFT_LEFT, 3'h0, 9'h000, 24'hf08100, 8'h21, 24'hf90200, 3'h2);
		run(OP_LOGIC_SHIFT_RIGHT, 3'h0, 9'h000, 24'hf00100, 8'h21, 24'hfb0000, 3'h2);
		run(OP_ROTATE_UP_THROUGH_CARRY, 3'h0, 9'h000, 24'h018000, 8'h21, 24'h090100, 3'h2);
		run(OP_ROTATE_DOWN_THROUGH_CARRY, 3'h0, 9'h000, 24'h010100, 8'h21, 24'h058000, 3'h2);
		run(OP_ARITH_SHIFT_RIGHT, 3'h0, 9'h000, 24'h008200, 8'h21, 24'h0cc100, 3'h2);
		run(OP_NIBBLE_SWAP, 3'h0, 9'h000, 24'ha53c00, 8'h21, 24'ha5c300, 3'h2);
		run(OP_REG_BIT_TO_TRANSFER, 3'h4, 9'h000, 24'hffef00, 8'h21, 24'hbfef00, 3'h2);
		run(OP_TRANSFER_TO_REG_BIT, 3'h1, 9'h000, 24'h400000, 8'h21, 24'h400200, 3'h2);
		run(OP_TRANSFER_TO_REG_BIT, 3'h1, 9'h000, 24'hbfff00, 8'h21, 24'hbffd00, 3'h2);
		// generic flag branches and forces over every flag
		for (int s = 0; s < 8; s++) begin
			m = 8'h01 << s;
			run(OP_BRANCH_ON_FLAG_ONE, 3'(s), 9'h07e, {m, 16'h0}, 8'h1f, {m, 16'h0}, 3'h5);
			run(OP_BRANCH_ON_FLAG_ZERO, 3'(s), 9'h003, {m, 16'h0}, 8'h21, {m, 16'h0}, 3'h2);
			run(OP_BRANCH_ON_FLAG_ZERO, 3'(s), 9'h003, {~m, 16'h0}, 8'h24, {~m, 16'h0},
				3'h5);
			run(OP_FLAG_FORCE_ONE, 3'(s), 9'h0, 24'h0, 8'h21, {m, 16'h0}, 3'h2);
			run(OP_FLAG_FORCE_ZERO, 3'(s), 9'h0, 24'hff0000, 8'h21, {~m, 16'h0}, 3'h2);
		end
		// every named branch against several flag patterns
		foreach (fl[i]) begin
			for (int o = OP_BRANCH_EQUAL; o <= OP_BRANCH_IRQ_DISABLED; o++) begin
				t = tk(6'(o), fl[i]);
				run(6'(o), 3'h0, 9'h003, {fl[i], 16'h5a5a},
					t ? 8'h24 : 8'h21, {fl[i], 16'h5a5a},
					t ? 3'h5 : 3'h2);
			end
		end
		// dedicated single flag forces
		for (int o = OP_CARRY_FORCE_ONE; o <= OP_GLOBAL_IRQ_OFF; o++) begin
			m = 8'h01 << fb[(o - OP_CARRY_FORCE_ONE) / 2];
			f0 = o[0] ? 8'hff : 8'h00;
			run(6'(o), 3'h0, 9'h0, {f0, 16'h0}, 8'h21, {f0 ^ m, 16'h0}, 3'h2);
		end
		// refused accesses, including a write during a three cycle skip
		err(1'b1, 8'h1c, 32'h0);
		err(1'b0, 8'h1c, 32'h0);
		err(1'b1, OFF_STAT, 32'h0);
		err(1'b1, OFF_CMD, 32'h2c);
		apb(1'b1, OFF_PC, 32'h20);
		apb(1'b1, OFF_GPR, 32'h0);
		apb(1'b1, OFF_OPND, 32'h100);
		apb(1'b1, OFF_CMD, 32'h0);
		err(1'b1, OFF_PC, 32'h1234);
		apb(1'b0, OFF_STAT, 32'h0);
		rc("pc", OFF_PC, 32'h23);
		give_verdict();
	end
endmodule
